// ### tsp_consts.svh
// constants for the touch sensor serial target port
// assumes inclusion by the port module only, not by tsp_pkg.sv
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH
`define TSP_ADDR_BASE     7'h16
`define TSP_CLK_HZ        25000000
`define TSP_POR_TIME_MS   20
`define TSP_POR_CYCLES    ((`TSP_CLK_HZ / 1000) * `TSP_POR_TIME_MS)
`define TSP_REG_AW        8
`define TSP_BIT_CNT_LAST  4'h8
`endif

// ### tsp_pkg.sv
// types for the touch sensor serial target port
// needs nothing from tsp_consts.svh, which it does not include
package tsp_pkg;
	typedef enum logic [2:0]
	{
		TSP_IDLE  = 3'b000,
		TSP_ADDR  = 3'b001,
		TSP_AACK  = 3'b010,
		TSP_WBYTE = 3'b011,
		TSP_WACK  = 3'b100,
		TSP_RBYTE = 3'b101,
		TSP_RACK  = 3'b110,
		TSP_SKIP  = 3'b111
	} tsp_state_t;
endpackage

// ### tsp_port.sv
// serial target port: address match, register address, auto-increment access
// assumes scl/sda inputs already synchronous to core_clk, register file outside
// Notes on behaviour
// - straps pick address 0x16 to 0x19
// - write: address, register index, data, auto-increment
// - read after repeated start, incrementing register index
// - internal reset held for power-on interval
// - interrupt pin high during reset, low after
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_port
	import tsp_pkg::*;
#(
	parameter int POR_CYCLES = `TSP_POR_CYCLES
)
(
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// address straps
	input  wire logic       addr_strap_low,
	input  wire logic       addr_strap_high,
	// bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// register file side
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	// readiness
	output logic            irq_output_pin
);
	tsp_state_t  state_reg, state_next;
	logic        scl_d_reg, sda_d_reg;
	logic [7:0]  sh_reg;
	logic [3:0]  bcnt_reg;
	logic        read_reg;
	logic        have_idx_reg;
	logic [31:0] por_cnt_reg;
	logic        por_reg;
	logic [7:0]  addr_reg, wdata_reg;
	logic        wr_reg, rd_reg, sda_oe_reg;

	wire scl_rise = scl_in && !scl_d_reg;
	wire scl_fall = !scl_in && scl_d_reg;
	wire start_c  = scl_in && scl_d_reg && sda_d_reg && !sda_in;
	wire stop_c   = scl_in && scl_d_reg && !sda_d_reg && sda_in;
	wire [6:0] my_addr = `TSP_ADDR_BASE + {5'h00, addr_strap_high, addr_strap_low};
	wire byte_done = (bcnt_reg == `TSP_BIT_CNT_LAST);
	wire addr_hit  = (sh_reg[7:1] == my_addr);
	wire run       = clk_en && !por_reg;

	// power-on hold; reset interval counted in core clocks
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			por_cnt_reg <= 32'h00000000;
			por_reg     <= 1'b1;
		end
		else if (clk_en && por_reg)
		begin
			por_cnt_reg <= por_cnt_reg + 32'h00000001;
			if (por_cnt_reg >= POR_CYCLES - 1)
				por_reg <= 1'b0;
		end
	end
	assign irq_output_pin = por_reg; // por_reg is a flip-flop

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			TSP_ADDR:  if (scl_fall && byte_done)
					state_next = addr_hit ? TSP_AACK : TSP_SKIP;
			TSP_AACK:  if (scl_fall)
					state_next = read_reg ? TSP_RBYTE : TSP_WBYTE;
			TSP_WBYTE: if (scl_fall && byte_done)
					state_next = TSP_WACK;
			TSP_WACK:  if (scl_fall)
					state_next = TSP_WBYTE;
			TSP_RBYTE: if (scl_fall && byte_done)
					state_next = TSP_RACK;
			TSP_RACK:  if (scl_rise)
					state_next = sda_in ? TSP_SKIP : TSP_RACK;
			default:   state_next = state_reg;
		endcase
		if (state_reg == TSP_RACK && scl_fall)
			state_next = TSP_RBYTE;
		if (start_c)
			state_next = TSP_ADDR;
		else if (stop_c)
			state_next = TSP_IDLE;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_reg    <= TSP_IDLE;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			sh_reg       <= 8'h00;
			bcnt_reg     <= 4'h0;
			read_reg     <= 1'b0;
			have_idx_reg <= 1'b0;
			addr_reg     <= 8'h00;
			wdata_reg    <= 8'h00;
			wr_reg       <= 1'b0;
			rd_reg       <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end
		else if (run)
		begin
			scl_d_reg <= scl_in;
			sda_d_reg <= sda_in;
			state_reg <= state_next;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			if (start_c || stop_c)
				bcnt_reg <= 4'h0;
			else if (scl_rise && (state_reg == TSP_ADDR || state_reg == TSP_WBYTE))
			begin
				sh_reg   <= {sh_reg[6:0], sda_in};
				bcnt_reg <= bcnt_reg + 4'h1;
			end
			// read bits counted where the controller samples them, so the
			// eighth fall closes the byte and frees the line for its ack
			else if (scl_rise && state_reg == TSP_RBYTE)
				bcnt_reg <= bcnt_reg + 4'h1;
			else if (scl_fall && byte_done)
				bcnt_reg <= 4'h0;
			else if (scl_fall && state_reg == TSP_RBYTE)
				sh_reg <= {sh_reg[6:0], 1'b1};
			if (stop_c)
				have_idx_reg <= 1'b0;
			if (scl_fall && byte_done && state_reg == TSP_ADDR)
			begin
				read_reg <= sh_reg[0];
				if (!sh_reg[0])
					have_idx_reg <= 1'b0;
			end
			if (scl_fall && byte_done && state_reg == TSP_WBYTE)
			begin
				if (!have_idx_reg)
				begin
					addr_reg     <= sh_reg;
					have_idx_reg <= 1'b1;
				end
				else
				begin
					wdata_reg <= sh_reg;
					wr_reg    <= 1'b1;
				end
			end
			if (wr_reg || rd_reg)
				addr_reg <= addr_reg + 8'h01;
			// load read byte on the falling edge that opens each read byte
			if (scl_fall && ((state_reg == TSP_AACK && read_reg) || state_reg == TSP_RACK))
			begin
				sh_reg <= reg_rdata;
				rd_reg <= 1'b1;
			end
			if (start_c || stop_c)
				sda_oe_reg <= 1'b0;
			else if (scl_fall)
			begin
				if (byte_done && addr_hit && state_reg == TSP_ADDR)
					sda_oe_reg <= 1'b1;
				else if (byte_done && state_reg == TSP_WBYTE)
					sda_oe_reg <= 1'b1;
				else if (state_reg == TSP_AACK && read_reg)
					sda_oe_reg <= !reg_rdata[7];
				else if (state_reg == TSP_RACK)
					sda_oe_reg <= !reg_rdata[7];
				else if (state_reg == TSP_RBYTE && !byte_done)
					sda_oe_reg <= !sh_reg[6];
				else
					sda_oe_reg <= 1'b0;
			end
		end
	end

	assign sda_out   = 1'b0;
	assign sda_oe    = sda_oe_reg;
	assign reg_addr  = addr_reg;
	assign reg_wdata = wdata_reg;
	assign reg_wr    = wr_reg;
	assign reg_rd    = rd_reg;

	a_ready_low: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(irq_output_pin) |-> (por_cnt_reg == POR_CYCLES))
		else $error("interrupt pin fell before the hold interval ended");
	a_por_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		(por_cnt_reg < POR_CYCLES - 1) |-> por_reg)
		else $error("power-on hold released early");
	a_foreign_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
		(state_reg == TSP_SKIP) |-> !sda_oe)
		else $error("driving data line for foreign address");
	a_wr_incr: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		wr_reg |=> (addr_reg == $past(addr_reg) + 8'h01))
		else $error("write index did not advance");
	a_rd_incr: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		rd_reg |=> (addr_reg == $past(addr_reg) + 8'h01))
		else $error("read index did not advance");
	a_nack_end: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		(run && state_reg == TSP_RACK && scl_rise && sda_in && !start_c && !stop_c)
		|=> state_reg == TSP_SKIP)
		else $error("read went on after nack");
	a_addr_ack: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		(run && state_reg == TSP_ADDR && scl_fall && byte_done && addr_hit && !start_c
		&& !stop_c) |=> sda_oe)
		else $error("own address not acknowledged");
	a_stop_idle: assert property (@(posedge core_clk) disable iff (sys_rst || !clk_en)
		(run && stop_c) |=> (state_reg == TSP_IDLE && !sda_oe))
		else $error("stop did not release port");
endmodule

// ### tsp_host_model.sv
// bus controller model: drives scl and data, reads back the wired-and data line
// assumes core_clk from the bench and the target's open-drain data enable
`timescale 1ns/1ps
module tsp_host_model
(
	// clock
	input  wire logic core_clk,
	// target data drive
	input  wire logic sda_out,
	input  wire logic sda_oe,
	// bus lines
	output logic      scl,
	output logic      sda
);
	logic scl_drv = 1'b1;
	logic sda_drv = 1'b1;
	// pull-ups on both lines, so a released line reads high
	assign scl = scl_drv;
	assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
	// four core clocks a phase, above the three-clock minimum
	task automatic wait4();
		repeat (4) @(posedge core_clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		wait4();
		scl_drv <= 1'b1;
		wait4();
		r = sda;
		scl_drv <= 1'b0;
		wait4();
	endtask
	// also serves as repeated start from a low clock
	task automatic start_cond();
		sda_drv <= 1'b1;
		wait4();
		scl_drv <= 1'b1;
		wait4();
		sda_drv <= 1'b0;
		wait4();
		scl_drv <= 1'b0;
		wait4();
	endtask
	task automatic stop_cond();
		sda_drv <= 1'b0;
		wait4();
		scl_drv <= 1'b1;
		wait4();
		sda_drv <= 1'b1;
		wait4();
	endtask
	// ack_in low acks a returned byte, high nacks the last one
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack_in, ack);
	endtask
endmodule

// ### tb_touch_sensor_i2c_target_port.sv
// self-checking bench for the serial target port
// assumes the host model and a behavioural register file on the index side
`timescale 1ns/1ps
`define TSP_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_touch_sensor_i2c_target_port;
	localparam int POR = 16;
	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       addr_strap_low = 1'b0;
	logic       addr_strap_high = 1'b0;
	logic       clk_en = 1'b1;
	int         n_rd = 0;
	logic       scl, sda, sda_out, sda_oe, reg_wr, reg_rd, irq, ack;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic [7:0] mem [256];
	int         n_errors = 0;
	int         comparisons = 0;
	initial
	begin
		forever #20 core_clk = ~core_clk;
	end
	assign reg_rdata = mem[reg_addr];
	always @(posedge core_clk)
		if (reg_wr === 1'b1)
			mem[reg_addr] <= reg_wdata;
	always @(posedge core_clk)
		if (reg_rd === 1'b1)
			n_rd <= n_rd + 1;
	tsp_port #(.POR_CYCLES(POR)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_output_pin(irq));
	tsp_host_model i_host (.core_clk(core_clk), .sda_out(sda_out), .sda_oe(sda_oe),
		.scl(scl), .sda(sda));
	task automatic complete_run();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hold frozen by the clock enable for 8 clocks, so release lands 8 clocks later
	task automatic por_check();
		@(posedge core_clk);
		clk_en <= 1'b0;
		#1;
		`TSP_CHK(irq, 1'b1)
		repeat (8) @(posedge core_clk);
		clk_en <= 1'b1;
		repeat (POR - 4) @(posedge core_clk);
		#1;
		`TSP_CHK(irq, 1'b1)
		repeat (2) @(posedge core_clk);
		#1;
		`TSP_CHK(irq, 1'b1)
		@(posedge core_clk);
		#1;
		`TSP_CHK(irq, 1'b0)
	endtask
	// each strap setting, then a neighbour address that must be refused
	task automatic addr_select();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge core_clk);
			{addr_strap_high, addr_strap_low} <= 2'(k);
			i_host.start_cond();
			i_host.xfer({7'h16 + 7'(k), 1'b0}, 1'b1, q, ack);
			`TSP_CHK(ack, 1'b0)
			i_host.stop_cond();
			i_host.start_cond();
			i_host.xfer({7'h16 + 7'((k + 1) % 4), 1'b0}, 1'b1, q, ack);
			`TSP_CHK(ack, 1'b1)
			i_host.xfer(8'h40, 1'b1, q, ack);
			`TSP_CHK(ack, 1'b1)
			i_host.stop_cond();
		end
	endtask
	task automatic write_read();
		@(posedge core_clk);
		{addr_strap_high, addr_strap_low} <= 2'h0;
		i_host.start_cond();
		i_host.xfer(8'h2C, 1'b1, q, ack);
		i_host.xfer(8'hFE, 1'b1, q, ack);
		i_host.xfer(8'hA5, 1'b1, q, ack);
		i_host.xfer(8'h3C, 1'b1, q, ack);
		`TSP_CHK(ack, 1'b0)
		i_host.stop_cond();
		`TSP_CHK(mem[8'hFE], 8'hA5)
		`TSP_CHK(mem[8'hFF], 8'h3C)
		i_host.start_cond();
		i_host.xfer(8'h2C, 1'b1, q, ack);
		i_host.xfer(8'hFE, 1'b1, q, ack);
		i_host.start_cond();
		i_host.xfer(8'h2D, 1'b1, q, ack);
		`TSP_CHK(ack, 1'b0)
		i_host.xfer(8'hFF, 1'b0, q, ack);
		`TSP_CHK(q, 8'hA5)
		i_host.xfer(8'hFF, 1'b1, q, ack);
		`TSP_CHK(q, 8'h3C)
		i_host.stop_cond();
		`TSP_CHK(sda_oe, 1'b0)
		`TSP_CHK(n_rd, 2)
		`TSP_CHK(reg_addr, 8'h00)
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		por_check();
		addr_select();
		write_read();
		complete_run();
	end
	// whole run needs a few thousand clocks
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		complete_run();
	end
endmodule
